// File: press_regs.svh
// Purpose: Constants for the press stroke sequencer.
// Assumes: One 125 MHz clock; inputs arrive asynchronously from machine pins.
// Notes:   Definitions only.
`ifndef PRESS_REGS_SVH
`define PRESS_REGS_SVH

// Depth of the input synchroniser chain.
`define SYNC_STAGES   2
// Reset value of all actuator outputs.
`define OUT_RESET     1'b0

`endif

// File: press_pkg.sv
// Purpose: Types shared by the press stroke sequencer files.
// Assumes: Included after press_regs.svh.
// Notes:   Inputs and outputs travel as packed structs.
package press_pkg;

    // Operator and machine inputs, one bit each.
    typedef struct packed {
        logic emergency_stop_ok;
        logic optical_sensor_ok;
        logic run_mode;
        logic top_of_stroke;
        logic bottom_of_stroke;
        logic manual_reset_input;
        logic two_hand_cycle_start;
        logic part_in_place;
        logic sequential_stop_input;
        logic press_mute_sensor_input;
        logic foot_switch_input;
    } press_in_s;

    // Actuator outputs.
    typedef struct packed {
        logic up_stroke_output;
        logic down_stroke_output;
        logic high_pressure_output;
        logic low_pressure_output;
    } press_out_s;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ARMED,
        ST_DOWN,
        ST_DOWN_HOLD,
        ST_SEQ_STOP,
        ST_DOWN_HIGH,
        ST_BOTTOM,
        ST_UP,
        ST_DONE,
        ST_FAULT
    } seq_state_e;

endpackage

// File: input_sync.sv
// Purpose: Two-stage synchroniser for a bus of pin inputs.
// Assumes: Inputs are static levels from outside the clock domain.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
`include "press_regs.svh"
module input_sync #(
    parameter int WIDTH = 11
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Raw and synchronised levels.
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta_reg;

    // Two flip-flops per bit; reset clears both stages.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            synced   <= '0;
        end else begin
            meta_reg <= raw;
            synced   <= meta_reg;
        end
    end

endmodule // input_sync

// File: press_stroke_sequencer.sv
// Purpose: Stroke sequencer for a hydraulic or pneumatic press.
// Assumes: All inputs are asynchronous levels, active high when asserted or healthy.
// Notes:   Outputs are registered; each change lands one scan after the synchronised input.
// Notes on behaviour
// - Safeties, top of stroke and run on: manual reset enables, low pressure on.
// - Enabled with part in place: cycle start turns down stroke on.
// - Top released, stop and mute sensor both on: down and low off, high on.
// - After stop, cycle start released, foot switch restarts the down stroke.
// - Bottom of stroke: down and high off, low pressure back on.
// - After bottom, foot switch released, cycle start turns up stroke on.
// - Top of stroke during up stroke turns up stroke off, cycle ends.
// - Start released then reasserted in down stroke keeps the down stroke going.
// - Start released mid down, then reset and start gives an up stroke.
// - Safety lost in stroke: release start, cycle reset, next start goes up.
`timescale 1ns/1ns
`include "press_regs.svh"
module press_stroke_sequencer (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Machine and operator inputs.
    input  wire press_pkg::press_in_s pins_in,
    // Actuator outputs.
    output press_pkg::press_out_s     pins_out,
    // Sequencer enabled indication.
    output logic                      enabled
);

    press_pkg::press_in_s  in_s;
    press_pkg::press_in_s  prev_reg;
    press_pkg::seq_state_e state_reg;
    press_pkg::seq_state_e state_next;
    press_pkg::press_out_s out_next;
    logic                  start_dropped_reg;
    logic                  start_dropped_next;
    logic                  part_cycled_reg;
    logic                  part_cycled_next;
    logic                  optic_broken_reg;
    logic                  optic_broken_next;

    // Every pin passes two flip-flops before logic reads it.
    input_sync #(
        .WIDTH ($bits(press_pkg::press_in_s))
    ) u_sync (
        .clk    (clk),
        .rst    (rst),
        .raw    (pins_in),
        .synced (in_s)
    );

    // Decoded conditions.
    wire safe_ok     = in_s.emergency_stop_ok & in_s.optical_sensor_ok;
    wire reset_rise  = in_s.manual_reset_input & ~prev_reg.manual_reset_input;
    wire start_rise  = in_s.two_hand_cycle_start & ~prev_reg.two_hand_cycle_start;
    wire part_fall   = ~in_s.part_in_place & prev_reg.part_in_place;
    wire optic_fall  = ~in_s.optical_sensor_ok & prev_reg.optical_sensor_ok;
    wire stopping    = in_s.sequential_stop_input & in_s.press_mute_sensor_input;
    wire in_stroke   = (state_reg == press_pkg::ST_DOWN) || (state_reg == press_pkg::ST_DOWN_HOLD) ||
                       (state_reg == press_pkg::ST_DOWN_HIGH) || (state_reg == press_pkg::ST_UP) ||
                       (state_reg == press_pkg::ST_SEQ_STOP) || (state_reg == press_pkg::ST_BOTTOM);
    wire rearm_ok    = safe_ok & in_s.top_of_stroke & in_s.run_mode;

    // Next state and next output values.
    always_comb begin
        state_next         = state_reg;
        out_next           = pins_out;
        start_dropped_next = start_dropped_reg;
        part_cycled_next   = part_cycled_reg | (optic_broken_reg & part_fall);
        optic_broken_next  = optic_broken_reg | optic_fall;
        if (in_stroke && !safe_ok) begin
            state_next                  = press_pkg::ST_FAULT;
            out_next.up_stroke_output   = 1'b0;
            out_next.down_stroke_output = 1'b0;
            out_next.high_pressure_output = 1'b0;
            start_dropped_next          = 1'b0;
        end else begin
            unique case (state_reg)
                press_pkg::ST_IDLE: begin
                    if (reset_rise && rearm_ok) begin
                        state_next                   = press_pkg::ST_ARMED;
                        out_next.low_pressure_output = 1'b1;
                    end
                end
                press_pkg::ST_ARMED: begin
                    if (start_rise && in_s.part_in_place && safe_ok) begin
                        state_next                  = press_pkg::ST_DOWN;
                        out_next.down_stroke_output = 1'b1;
                        start_dropped_next          = 1'b0;
                    end
                end
                press_pkg::ST_DOWN, press_pkg::ST_DOWN_HOLD: begin
                    if (!in_s.two_hand_cycle_start) begin
                        start_dropped_next = 1'b1;
                    end
                    if (!in_s.top_of_stroke && stopping) begin
                        state_next                    = press_pkg::ST_SEQ_STOP;
                        out_next.down_stroke_output   = 1'b0;
                        out_next.low_pressure_output  = 1'b0;
                        out_next.high_pressure_output = 1'b1;
                    end else if (in_s.bottom_of_stroke) begin
                        state_next                  = press_pkg::ST_BOTTOM;
                        out_next.down_stroke_output = 1'b0;
                    end else if (start_dropped_reg && reset_rise) begin
                        state_next = press_pkg::ST_DOWN_HOLD;
                    end else if (state_reg == press_pkg::ST_DOWN_HOLD && start_rise) begin
                        state_next                  = press_pkg::ST_UP;
                        out_next.down_stroke_output = 1'b0;
                        out_next.up_stroke_output   = 1'b1;
                    end
                end
                press_pkg::ST_SEQ_STOP: begin
                    if (!in_s.two_hand_cycle_start && in_s.foot_switch_input) begin
                        state_next                  = press_pkg::ST_DOWN_HIGH;
                        out_next.down_stroke_output = 1'b1;
                    end
                end
                press_pkg::ST_DOWN_HIGH: begin
                    if (in_s.bottom_of_stroke) begin
                        state_next                    = press_pkg::ST_BOTTOM;
                        out_next.down_stroke_output   = 1'b0;
                        out_next.high_pressure_output = 1'b0;
                        out_next.low_pressure_output  = 1'b1;
                    end
                end
                press_pkg::ST_BOTTOM: begin
                    if (!in_s.foot_switch_input && start_rise) begin
                        state_next                = press_pkg::ST_UP;
                        out_next.up_stroke_output = 1'b1;
                    end
                end
                press_pkg::ST_UP: begin
                    if (in_s.top_of_stroke) begin
                        state_next                = press_pkg::ST_DONE;
                        out_next.up_stroke_output = 1'b0;
                        optic_broken_next         = 1'b0;
                        part_cycled_next          = 1'b0;
                    end
                end
                press_pkg::ST_DONE: begin
                    // Next cycle once the operator has done the rearm ritual.
                    if (part_cycled_reg && in_s.optical_sensor_ok && in_s.part_in_place &&
                        !in_s.two_hand_cycle_start) begin
                        state_next = press_pkg::ST_ARMED;
                    end
                end
                press_pkg::ST_FAULT: begin
                    // The start edge is tested first, since a start edge also means start is high.
                    if (start_dropped_reg && start_rise && safe_ok) begin
                        state_next                = press_pkg::ST_UP;
                        out_next.up_stroke_output = 1'b1;
                    end else if (in_s.two_hand_cycle_start) begin
                        start_dropped_next = 1'b0;
                    end else if (reset_rise && safe_ok) begin
                        start_dropped_next = 1'b1;
                    end
                end
            endcase
        end
    end

    // State, outputs and edge history.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg         <= press_pkg::ST_IDLE;
            pins_out          <= '0;
            prev_reg          <= '0;
            start_dropped_reg <= 1'b0;
            part_cycled_reg   <= 1'b0;
            optic_broken_reg  <= 1'b0;
        end else begin
            state_reg         <= state_next;
            pins_out          <= out_next;
            prev_reg          <= in_s;
            start_dropped_reg <= start_dropped_next;
            part_cycled_reg   <= part_cycled_next;
            optic_broken_reg  <= optic_broken_next;
        end
    end

    assign enabled = (state_reg != press_pkg::ST_IDLE) && (state_reg != press_pkg::ST_FAULT);

    // Stroke outputs never both on.
    chk_stroke_exclusive: assert property (@(posedge clk) disable iff (rst)
        !(pins_out.up_stroke_output && pins_out.down_stroke_output))
        else $error("up and down stroke both on");

    // Safety loss mid stroke drops both strokes next scan.
    chk_safety_drop: assert property (@(posedge clk) disable iff (rst)
        (in_stroke && !safe_ok) |=> !pins_out.up_stroke_output && !pins_out.down_stroke_output)
        else $error("stroke output held after safety loss");

    // Reset edge with safeties arms and lights low pressure.
    chk_arm_low: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_IDLE && reset_rise && rearm_ok) |=> pins_out.low_pressure_output && enabled)
        else $error("arm did not raise low pressure");

    // Start with part turns the down stroke on.
    chk_down_start: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_ARMED && start_rise && in_s.part_in_place && safe_ok)
        |=> pins_out.down_stroke_output)
        else $error("down stroke not started");

    // Sequential stop swaps pressure.
    chk_seq_stop: assert property (@(posedge clk) disable iff (rst)
        $rose(pins_out.high_pressure_output) |-> !pins_out.down_stroke_output && !pins_out.low_pressure_output)
        else $error("sequential stop outputs wrong");

    // Bottom of stroke stops the down stroke.
    chk_bottom_stop: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_DOWN_HIGH && in_s.bottom_of_stroke && safe_ok)
        |=> !pins_out.down_stroke_output && !pins_out.high_pressure_output && pins_out.low_pressure_output)
        else $error("bottom did not stop down stroke");

    // Top of stroke ends the up stroke.
    chk_top_end: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_UP && in_s.top_of_stroke && safe_ok) |=> !pins_out.up_stroke_output)
        else $error("up stroke not ended at top");

    // Up stroke only rises on a cycle start edge.
    chk_up_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(pins_out.up_stroke_output) |-> $past(start_rise))
        else $error("up stroke without cycle start");

    // Start reasserted in a plain down stroke keeps going down.
    chk_down_keep: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_DOWN && start_rise && safe_ok && !in_s.bottom_of_stroke && !stopping)
        |=> pins_out.down_stroke_output)
        else $error("down stroke reversed");

    // Foot switch after stop resumes the down stroke.
    chk_foot_resume: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_SEQ_STOP && safe_ok && !in_s.two_hand_cycle_start && in_s.foot_switch_input)
        |=> pins_out.down_stroke_output)
        else $error("foot switch did not resume");

    // A fresh start after the reset edge in fault recovers with an up stroke.
    chk_fault_recover: assert property (@(posedge clk) disable iff (rst)
        (state_reg == press_pkg::ST_FAULT && start_dropped_reg && start_rise && safe_ok)
        |=> pins_out.up_stroke_output && !pins_out.down_stroke_output)
        else $error("fault recovery did not go up");

endmodule // press_stroke_sequencer

// File: press_rig.sv
// Purpose: Behavioural press ram that makes the stroke-end switches.
// Assumes: The ram moves one step per clock while a stroke output is on.
// Notes:   Operator levels pass through; only the two stroke ends are made here.
`timescale 1ns/1ns
module press_rig #(
    parameter int TRAVEL = 64
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Operator levels and actuator outputs.
    input  wire press_pkg::press_in_s  op_in,
    input  wire press_pkg::press_out_s act,
    // Pins towards the sequencer.
    output press_pkg::press_in_s       pins
);
    int pos_reg;
    // The ram starts at the top and stops at either end of its travel.
    always @(posedge clk) begin
        if (rst) begin
            pos_reg <= 0;
        end else if (act.down_stroke_output && pos_reg < TRAVEL) begin
            pos_reg <= pos_reg + 1;
        end else if (act.up_stroke_output && pos_reg > 0) begin
            pos_reg <= pos_reg - 1;
        end
    end
    // Stroke-end switches replace the bench's levels for those two bits.
    always_comb begin
        pins                  = op_in;
        pins.top_of_stroke    = (pos_reg == 0);
        pins.bottom_of_stroke = (pos_reg == TRAVEL);
    end
endmodule // press_rig

// File: tb_top.sv
// Purpose: Self-checking bench for the press stroke sequencer.
// Assumes: Outputs change once per sequence event, three edges after the pin.
// Notes:   The driver queues expected outputs; a monitor compares each change.
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    press_pkg::press_in_s  op = '0;
    press_pkg::press_in_s  pins_in;
    press_pkg::press_out_s pins_out;
    press_pkg::press_out_s ex = '0;
    press_pkg::press_out_s last_out;
    press_pkg::press_out_s exp_q[$];
    logic                  enabled;
    logic                  watch = 1'b0;
    logic [7:0]            lfsr_reg = 8'h17;
    int                    error_cnt = 0;
    int                    total_checks = 0;
    press_rig press_rig_inst (.clk(clk), .rst(rst), .op_in(op), .act(pins_out), .pins(pins_in));
    press_stroke_sequencer press_stroke_sequencer_inst (
        .clk(clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out), .enabled(enabled));
    // The clock toggles every half period of 4 ns.
    always #4 clk = ~clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Prints the verdict and ends the run.
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Compares two values and reports a mismatch.
    task automatic cmp(logic [3:0] e, logic [3:0] g);
        total_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Waits a number of rising edges.
    task automatic step(int n);
        repeat (n) @(posedge clk);
    endtask
    // Advances the pseudo-random sequence and returns its new value.
    function automatic logic [7:0] lfsr_next();
        lfsr_reg = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        return lfsr_reg;
    endfunction
    // Waits a random two to nine cycles; once armed, the run level is only read when idle, so it toggles freely.
    task automatic rwait();
        logic [7:0] r;
        r = lfsr_next();
        if (enabled) op.run_mode <= r[7];
        step(2 + r[2:0]);
    endtask
    // Notes the current expectation for the next output change.
    task automatic note();
        exp_q.push_back(ex);
    endtask
    // Waits, bounded, until every noted change has been seen.
    task automatic settle(int n);
        int i;
        for (i = 0; i < n && exp_q.size() != 0; i++) step(1);
        if (exp_q.size() != 0) begin
            cmp(4'h0, 4'hf);
            end_of_test();
        end
        step(4);
    endtask
    // Pulses the manual reset for three cycles.
    task automatic pulse_reset();
        op.manual_reset_input <= 1'b1;
        step(3);
        op.manual_reset_input <= 1'b0;
        step(3);
    endtask
    // Operator ritual between cycles: release start, break optical, cycle part.
    task automatic ritual();
        op.two_hand_cycle_start <= 1'b0;
        rwait();
        op.optical_sensor_ok <= 1'b0;
        rwait();
        op.part_in_place <= 1'b0;
        rwait();
        op.part_in_place <= 1'b1;
        rwait();
        op.optical_sensor_ok <= 1'b1;
        rwait();
    endtask
    // Each output change takes the oldest note, or ex when no note is queued, and compares against it.
    always @(posedge clk) begin
        if (watch && pins_out !== last_out) begin
            last_out = pins_out;
            if (exp_q.size() == 0) cmp(ex, pins_out);
            else cmp(exp_q.pop_front(), pins_out);
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        step(5);
        rst <= 1'b0;
        step(4);
        last_out = pins_out;
        watch = 1'b1;
        cmp(4'h0, pins_out);
        op.emergency_stop_ok <= 1'b1;
        op.optical_sensor_ok <= 1'b1;
        rwait();
        pulse_reset();
        settle(10);
        cmp(1'b0, enabled);
        op.run_mode <= 1'b1;
        rwait();
        ex.low_pressure_output = 1'b1;
        note();
        pulse_reset();
        settle(20);
        cmp(1'b1, enabled);
        op.part_in_place <= 1'b1;
        rwait();
        ex.down_stroke_output = 1'b1;
        note();
        op.two_hand_cycle_start <= 1'b1;
        settle(20);
        ex = 4'b0010;
        note();
        op.sequential_stop_input <= 1'b1;
        op.press_mute_sensor_input <= 1'b1;
        settle(20);
        op.two_hand_cycle_start <= 1'b0;
        rwait();
        ex = 4'b0110;
        note();
        op.foot_switch_input <= 1'b1;
        settle(20);
        ex = 4'b0001;
        note();
        settle(120);
        op.foot_switch_input <= 1'b0;
        rwait();
        ex = 4'b1001;
        note();
        op.two_hand_cycle_start <= 1'b1;
        settle(20);
        op.sequential_stop_input <= 1'b0;
        op.press_mute_sensor_input <= 1'b0;
        ex.up_stroke_output = 1'b0;
        note();
        settle(120);
        ritual();
        ex.down_stroke_output = 1'b1;
        note();
        op.two_hand_cycle_start <= 1'b1;
        settle(20);
        op.two_hand_cycle_start <= 1'b0;
        rwait();
        op.two_hand_cycle_start <= 1'b1;
        rwait();
        cmp(4'b0101, pins_out);
        op.two_hand_cycle_start <= 1'b0;
        rwait();
        pulse_reset();
        ex = 4'b1001;
        note();
        op.two_hand_cycle_start <= 1'b1;
        settle(20);
        ex = 4'b0001;
        note();
        settle(120);
        ritual();
        ex = 4'b0101;
        note();
        op.two_hand_cycle_start <= 1'b1;
        settle(20);
        ex = 4'b0001;
        note();
        op.optical_sensor_ok <= 1'b0;
        settle(20);
        cmp(1'b0, enabled);
        op.optical_sensor_ok <= 1'b1;
        rwait();
        op.two_hand_cycle_start <= 1'b0;
        rwait();
        pulse_reset();
        ex = 4'b1001;
        note();
        op.two_hand_cycle_start <= 1'b1;
        settle(20);
        ex = 4'b0001;
        note();
        settle(120);
        end_of_test();
    end
endmodule // tb_top
